// ### sfp_cfg.svh
// offsets, field positions and reset values of the serial format / power bank
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// word indices; byte address is four times the index
`define SFP_IDX_GLOBAL 6'h03
`define SFP_IDX_SERIAL 6'h04
`define SFP_IDX_POWER 6'h05

// serial input format control fields (lsb positions)
`define SFP_B_FMT_LSB 4'd11
`define SFP_B_WID_LSB 4'd9
`define SFP_A_FMT_LSB 4'd7
`define SFP_A_WID_LSB 4'd5
`define SFP_SYNC_MASTER_BIT 4'd4
`define SFP_SYNC_FMT_LSB 4'd2
`define SFP_SYNC_WID_LSB 4'd0

// analog block power enable fields and the DAC normal mode bit
`define SFP_DAC_NORMAL_BIT 4'd15
`define SFP_REF_BUF_BIT 4'd13
`define SFP_ADC_RIGHT_BIT 4'd10
`define SFP_ADC_LEFT_BIT 4'd9
`define SFP_AUX3_RIGHT_BIT 4'd6
`define SFP_AUX3_LEFT_BIT 4'd5
`define SFP_AUX1_RIGHT_BIT 4'd1
`define SFP_AUX1_LEFT_BIT 4'd0

// global power control field
`define SFP_GPU_BIT 4'd0

// implemented bits; all others read zero
`define SFP_SERIAL_MASK 16'h1fff
`define SFP_POWER_MASK 16'ha663
`define SFP_POWER_SWITCH_MASK 16'h2663
`define SFP_GLOBAL_MASK 16'h0001

// reset values
`define SFP_SERIAL_RST 16'h0000
`define SFP_POWER_RST 16'h8000
`define SFP_GLOBAL_RST 16'h0000

`endif

// ### sfp_pkg.sv
// types shared by the serial format / power register bank
package sfp_pkg;

    typedef enum logic [1:0] {
        FMT_I2S = 2'b00,
        FMT_LEFT_JUST = 2'b01,
        FMT_RIGHT_JUST = 2'b10,
        FMT_UNDEFINED = 2'b11
    } sfp_format_type;

    typedef enum logic [1:0] {
        WID_24 = 2'b00,
        WID_20 = 2'b01,
        WID_16 = 2'b10,
        WID_UNDEFINED = 2'b11
    } sfp_width_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] serial;
        logic [15:0] power;
        logic [15:0] global_ctrl;
        logic [15:0] power_eff;
        logic [2:0] cfg_valid;
        logic [4:0] a_bits;
        logic [4:0] b_bits;
        logic [4:0] sync_bits;
    } sfp_state_type;

    // word length in bits, zero for the undefined code
    function automatic logic [4:0] sfp_word_bits(input sfp_width_type w);
        logic [4:0] r;
        r = 5'h00;
        unique case (w)
            WID_24: r = 5'h18;
            WID_20: r = 5'h14;
            WID_16: r = 5'h10;
            WID_UNDEFINED: r = 5'h00;
        endcase
        return r;
    endfunction : sfp_word_bits

endpackage : sfp_pkg

// ### sfp_regs.sv
// serial input format control and analog block power enables, wishbone slave
// Contract
// - rate_converter_b format field: 00 I2S, 01 left, 10 right, 11 undefined.
// - rate_converter_b width field: 00 24 bits, 01 20, 10 16, 11 undefined.
// - rate_converter_a has its own format and width fields, same codes.
// - sync role bit: 0 slave, clocks from outside; 1 device drives them.
// - sync input format field: 00 I2S, 01 left, 10 right, 11 invalid.
// - sync input width field: 00 24 bits, 01 20, 10 16, 11 undefined.
// - power register resets to 0x8000, all blocks down, DAC normal mode.
// - power bit 15: 1 normal DAC mode, 0 low power; no power-up.
// - power bit 13 powers the voltage reference buffer.
// - bit 10 powers primary ADC right, bit 9 the left channel.
// - bit 6 powers aux DAC pair three right, bit 5 the left.
// - bit 1 powers aux DAC pair one right, bit 0 the left.
// - global power-up set powers everything; else individual bits rule.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`include "sfp_cfg.svh"

module sfp_regs #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [1:0] rate_converter_a_format_o,
    output logic [1:0] rate_converter_a_width_o,
    output logic [4:0] rate_converter_a_word_bits_o,
    output logic rate_converter_a_cfg_valid_o,
    output logic [1:0] rate_converter_b_format_o,
    output logic [1:0] rate_converter_b_width_o,
    output logic [4:0] rate_converter_b_word_bits_o,
    output logic rate_converter_b_cfg_valid_o,
    output logic sync_master_o,
    output logic [1:0] sync_format_o,
    output logic [1:0] sync_width_o,
    output logic [4:0] sync_word_bits_o,
    output logic sync_cfg_valid_o,
    output logic global_power_up_o,
    output logic dac_normal_mode_o,
    output logic ref_buf_power_o,
    output logic primary_adc_pair_right_power_o,
    output logic primary_adc_pair_left_power_o,
    output logic aux_dac_pair_three_right_power_o,
    output logic aux_dac_pair_three_left_power_o,
    output logic aux_dac_pair_one_right_power_o,
    output logic aux_dac_pair_one_left_power_o
);

    // refuse address widths that cannot hold the word index
    if (ADR_W < 5 || ADR_W > 32) begin : g_bad_adr_w
        $error("sfp_regs: ADR_W must lie in 5..32");
    end

    sfp_pkg::sfp_state_type s_q;
    sfp_pkg::sfp_state_type s_d;

    logic [ADR_W-3:0] word_idx;
    logic req;
    logic hit_global;
    logic hit_serial;
    logic hit_power;
    logic [15:0] byte_mask;

    assign word_idx = wb_adr_i[ADR_W-1:2];
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign hit_global = word_idx == (ADR_W-2)'(`SFP_IDX_GLOBAL);
    assign hit_serial = word_idx == (ADR_W-2)'(`SFP_IDX_SERIAL);
    assign hit_power = word_idx == (ADR_W-2)'(`SFP_IDX_POWER);
    assign byte_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // byte-lane merge, unimplemented bits forced to zero
    function automatic logic [15:0] merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [15:0] lanes,
        input logic [15:0] keep
    );
        return ((old_v & ~lanes) | (new_v & lanes)) & keep;
    endfunction : merge

    // both format and width must be defined codes
    function automatic logic path_ok(input logic [1:0] fmt, input logic [1:0] wid);
        return (fmt != sfp_pkg::FMT_UNDEFINED) && (wid != sfp_pkg::WID_UNDEFINED);
    endfunction : path_ok

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.rdata = 32'h0000_0000;

        // single-cycle answer, ack drops after one cycle
        if (req) begin
            s_d.ack = 1'b1;
            if (wb_we_i) begin
                if (hit_serial) begin
                    s_d.serial = merge(s_q.serial, wb_dat_i[15:0], byte_mask, `SFP_SERIAL_MASK);
                end
                if (hit_power) begin
                    s_d.power = merge(s_q.power, wb_dat_i[15:0], byte_mask, `SFP_POWER_MASK);
                end
                if (hit_global) begin
                    s_d.global_ctrl = merge(s_q.global_ctrl, wb_dat_i[15:0], byte_mask, `SFP_GLOBAL_MASK);
                end
            end else begin
                if (hit_serial) begin
                    s_d.rdata = {16'h0000, s_q.serial};
                end
                if (hit_power) begin
                    s_d.rdata = {16'h0000, s_q.power};
                end
                if (hit_global) begin
                    s_d.rdata = {16'h0000, s_q.global_ctrl};
                end
            end
        end

        if (rst_i) begin
            s_d.ack = 1'b0;
            s_d.rdata = 32'h0000_0000;
            s_d.serial = `SFP_SERIAL_RST;
            s_d.power = `SFP_POWER_RST;
            s_d.global_ctrl = `SFP_GLOBAL_RST;
        end

        // effective power switches follow the next register contents
        if (s_d.global_ctrl[`SFP_GPU_BIT]) begin
            s_d.power_eff = `SFP_POWER_SWITCH_MASK;
        end else begin
            s_d.power_eff = s_d.power & `SFP_POWER_SWITCH_MASK;
        end

        s_d.cfg_valid[0] = path_ok(s_d.serial[`SFP_A_FMT_LSB +: 2], s_d.serial[`SFP_A_WID_LSB +: 2]);
        s_d.cfg_valid[1] = path_ok(s_d.serial[`SFP_B_FMT_LSB +: 2], s_d.serial[`SFP_B_WID_LSB +: 2]);
        s_d.cfg_valid[2] = path_ok(s_d.serial[`SFP_SYNC_FMT_LSB +: 2], s_d.serial[`SFP_SYNC_WID_LSB +: 2]);

        s_d.a_bits = sfp_pkg::sfp_word_bits(sfp_pkg::sfp_width_type'(s_d.serial[`SFP_A_WID_LSB +: 2]));
        s_d.b_bits = sfp_pkg::sfp_word_bits(sfp_pkg::sfp_width_type'(s_d.serial[`SFP_B_WID_LSB +: 2]));
        s_d.sync_bits = sfp_pkg::sfp_word_bits(
            sfp_pkg::sfp_width_type'(s_d.serial[`SFP_SYNC_WID_LSB +: 2]));
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;

    // rate converter a
    assign rate_converter_a_format_o = s_q.serial[`SFP_A_FMT_LSB +: 2];
    assign rate_converter_a_width_o = s_q.serial[`SFP_A_WID_LSB +: 2];
    assign rate_converter_a_word_bits_o = s_q.a_bits;
    assign rate_converter_a_cfg_valid_o = s_q.cfg_valid[0];

    // rate converter b
    assign rate_converter_b_format_o = s_q.serial[`SFP_B_FMT_LSB +: 2];
    assign rate_converter_b_width_o = s_q.serial[`SFP_B_WID_LSB +: 2];
    assign rate_converter_b_word_bits_o = s_q.b_bits;
    assign rate_converter_b_cfg_valid_o = s_q.cfg_valid[1];

    // synchronous serial input; master drives bit and frame clocks
    assign sync_master_o = s_q.serial[`SFP_SYNC_MASTER_BIT];
    assign sync_format_o = s_q.serial[`SFP_SYNC_FMT_LSB +: 2];
    assign sync_width_o = s_q.serial[`SFP_SYNC_WID_LSB +: 2];
    assign sync_word_bits_o = s_q.sync_bits;
    assign sync_cfg_valid_o = s_q.cfg_valid[2];

    // analog power; dac mode is not a power switch
    assign global_power_up_o = s_q.global_ctrl[`SFP_GPU_BIT];
    assign dac_normal_mode_o = s_q.power[`SFP_DAC_NORMAL_BIT];
    assign ref_buf_power_o = s_q.power_eff[`SFP_REF_BUF_BIT];
    assign primary_adc_pair_right_power_o = s_q.power_eff[`SFP_ADC_RIGHT_BIT];
    assign primary_adc_pair_left_power_o = s_q.power_eff[`SFP_ADC_LEFT_BIT];
    assign aux_dac_pair_three_right_power_o = s_q.power_eff[`SFP_AUX3_RIGHT_BIT];
    assign aux_dac_pair_three_left_power_o = s_q.power_eff[`SFP_AUX3_LEFT_BIT];
    assign aux_dac_pair_one_right_power_o = s_q.power_eff[`SFP_AUX1_RIGHT_BIT];
    assign aux_dac_pair_one_left_power_o = s_q.power_eff[`SFP_AUX1_LEFT_BIT];

endmodule : sfp_regs

// ### sfp_regs_asserts.sv
// concurrent checks on the serial format / power register bank ports
`timescale 1ns/100ps
module sfp_regs_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] rate_converter_a_format_o,
    input wire logic [1:0] rate_converter_a_width_o,
    input wire logic rate_converter_a_cfg_valid_o,
    input wire logic [1:0] rate_converter_b_width_o,
    input wire logic [4:0] rate_converter_b_word_bits_o,
    input wire logic [1:0] sync_format_o,
    input wire logic [1:0] sync_width_o,
    input wire logic [4:0] sync_word_bits_o,
    input wire logic sync_cfg_valid_o,
    input wire logic sync_master_o,
    input wire logic global_power_up_o,
    input wire logic ref_buf_power_o,
    input wire logic aux_dac_pair_one_left_power_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    chk_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
    chk_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    chk_a_valid_codes: assert property (rate_converter_a_cfg_valid_o == (rate_converter_a_format_o != 2'h3 &&
        rate_converter_a_width_o != 2'h3)) else $error("path a valid flag wrong");
    chk_b_sixteen_bits: assert property (rate_converter_b_width_o == 2'h2 |->
        rate_converter_b_word_bits_o == 5'h10) else $error("path b word bits wrong");
    chk_sync_twenty_bits: assert property (sync_width_o == 2'h1 |-> sync_word_bits_o == 5'h14)
        else $error("sync word bits wrong");
    chk_sync_bad_format: assert property (sync_format_o == 2'h3 |-> !sync_cfg_valid_o)
        else $error("sync invalid format flagged valid");
    chk_role_on_write: assert property ($changed(sync_master_o) |-> wb_ack_o) else $error("role moved without write");
    chk_global_forces: assert property (global_power_up_o |-> ref_buf_power_o && aux_dac_pair_one_left_power_o)
        else $error("global power-up not forcing blocks on");
    cover property (wb_ack_o && sync_master_o);
    cover property (global_power_up_o);
    cover property (!sync_cfg_valid_o);
endmodule : sfp_regs_chk

bind sfp_regs sfp_regs_chk chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rate_converter_a_format_o(rate_converter_a_format_o),
    .rate_converter_a_width_o(rate_converter_a_width_o), .rate_converter_a_cfg_valid_o(rate_converter_a_cfg_valid_o),
    .rate_converter_b_width_o(rate_converter_b_width_o), .rate_converter_b_word_bits_o(rate_converter_b_word_bits_o),
    .sync_format_o(sync_format_o), .sync_width_o(sync_width_o), .sync_word_bits_o(sync_word_bits_o),
    .sync_cfg_valid_o(sync_cfg_valid_o), .sync_master_o(sync_master_o), .global_power_up_o(global_power_up_o),
    .ref_buf_power_o(ref_buf_power_o), .aux_dac_pair_one_left_power_o(aux_dac_pair_one_left_power_o));

// ### tb.sv
// self-checking bench for the serial format / power register bank
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rd, e;
    logic [1:0] af, aw, bf, bw, sf, sw;
    logic [4:0] awb, bwb, swb;
    logic av, bv, sv, sm, gp, dn, rb, ar, al, a3r, a3l, a1r, a1l;
    logic [31:0] q[$];
    integer seed = 32'hef00;
    int n_mismatch = 0, n_checks = 0;
    sfp_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .rate_converter_a_format_o(af),
        .rate_converter_a_width_o(aw), .rate_converter_a_word_bits_o(awb), .rate_converter_a_cfg_valid_o(av),
        .rate_converter_b_format_o(bf), .rate_converter_b_width_o(bw), .rate_converter_b_word_bits_o(bwb),
        .rate_converter_b_cfg_valid_o(bv), .sync_master_o(sm), .sync_format_o(sf), .sync_width_o(sw),
        .sync_word_bits_o(swb), .sync_cfg_valid_o(sv), .global_power_up_o(gp), .dac_normal_mode_o(dn),
        .ref_buf_power_o(rb), .primary_adc_pair_right_power_o(ar), .primary_adc_pair_left_power_o(al),
        .aux_dac_pair_three_right_power_o(a3r), .aux_dac_pair_three_left_power_o(a3l),
        .aux_dac_pair_one_right_power_o(a1r), .aux_dac_pair_one_left_power_o(a1l));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic bad(input string m);
        n_mismatch++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic chk(input logic [15:0] g, input logic [15:0] x, input string m);
        n_checks++;
        if (g !== x) bad(m);
    endtask : chk
    function automatic logic [4:0] bits(input logic [1:0] w);
        return (w == 2'h0) ? 5'h18 : (w == 2'h1) ? 5'h14 : (w == 2'h2) ? 5'h10 : 5'h00;
    endfunction : bits
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        if (!w) q.push_back({16'h0, d});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {16'h0, d};
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic sr(input logic [15:0] v);
        chk({3'h0, bf, bw, af, aw, sm, sf, sw}, v & 16'h1fff, "serial fields");
        chk({1'b0, awb, bwb, swb}, {1'b0, bits(v[6:5]), bits(v[10:9]), bits(v[1:0])}, "word bits");
        chk({13'h0, av, bv, sv}, {13'h0, v[8:7] != 2'h3 && v[6:5] != 2'h3, v[12:11] != 2'h3 && v[10:9] != 2'h3,
            v[3:2] != 2'h3 && v[1:0] != 2'h3}, "cfg valid");
    endtask : sr
    task automatic pw(input logic [15:0] v, input logic g);
        chk({7'h0, gp, dn, rb, ar, al, a3r, a3l, a1r, a1l}, {7'h0, g, v[15], {v[13], v[10], v[9], v[6], v[5], v[1],
            v[0]} | {7{g}}}, "power outs");
    endtask : pw
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we) begin
            if (q.size() == 0) bad("unexpected read");
            else begin
                e = q.pop_front();
                n_checks++;
                if (rd !== e) bad("read data");
            end
        end
    end
    task automatic give_verdict;
        if (q.size() != 0) bad("reads missing");
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge clk_i);
        bad("timeout");
        give_verdict();
    end
    initial begin
        logic [15:0] v, s;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        pw(16'h8000, 1'b0);
        sr(16'h0000);
        bus(1'b0, 8'h14, 16'h8000, 4'h3);
        for (int i = 0; i < 16; i++) begin
            s = 16'($random(seed)) & 16'h1fff;
            bus(1'b1, 8'h10, s, 4'h3);
            sr(s);
            bus(1'b0, 8'h10, s, 4'h3);
            v = 16'($random(seed)) & 16'ha663;
            bus(1'b1, 8'h14, v, 4'h3);
            pw(v, 1'b0);
            bus(1'b0, 8'h14, v, 4'h3);
        end
        bus(1'b1, 8'h14, 16'h0000, 4'h1);
        v = v & 16'hff00;
        pw(v, 1'b0);
        bus(1'b1, 8'h0c, 16'h0001, 4'h3);
        pw(v, 1'b1);
        bus(1'b0, 8'h14, v, 4'h3);
        bus(1'b1, 8'h0c, 16'h0000, 4'h3);
        pw(v, 1'b0);
        bus(1'b1, 8'h20, 16'h1fff, 4'h3);
        bus(1'b0, 8'h20, 16'h0000, 4'h3);
        sr(s);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        pw(16'h8000, 1'b0);
        sr(16'h0000);
        bus(1'b0, 8'h10, 16'h0000, 4'h3);
        give_verdict();
    end
endmodule : tb
